// *** gzsc_motor_model.sv ***
// Purpose: Sense bit model of the step motor
// Assumes: Only one coil driven at once
// Notes: moving_i picks a free or a stalled pointer
`timescale 1ns/1ns
`default_nettype none
module gzsc_motor_model (
  input wire logic clock_i,
  input wire logic coil_a_en_i,
  input wire logic coil_b_en_i,
  input wire logic moving_i,
  output logic sense_bit_o
);
  logic idle_q = 1'b0;
  // Open coils read noise, never a steady level
  always @(posedge clock_i) idle_q <= ~idle_q;
  assign sense_bit_o = (coil_a_en_i || coil_b_en_i) ? moving_i : idle_q;
endmodule
`default_nettype wire

// *** gzsc_pkg.sv ***
// Purpose: Constants and types for the gauge zeroing step and stall block
// Assumes: 250 MHz core clock
// Notes: Times are kept in ns, cycle counts are derived from them

package gzsc_pkg;

  // --------------------------------------------------------------
  // Configuration word
  // --------------------------------------------------------------
  localparam logic [2:0] ZSC_ADDR = 3'h5;
  localparam int CFG_W = 13;
  localparam int MULT_LSB = 11;
  localparam int PRE_LSB = 5;
  localparam int BLANK_BIT = 4;
  localparam int DELTA_LSB = 0;
  localparam logic [1:0] MULT_RST = 2'h0;
  localparam logic [5:0] PRE_RST = 6'h00;
  localparam logic BLANK_RST = 1'b0;
  localparam logic [3:0] DELTA_RST = 4'h3;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int DT_UNIT_NS = 4096000;
  localparam int BLANK0_NS = 512000;
  localparam int BLANK1_NS = 768000;
  localparam int FIX_NS = 2048000;
  localparam int SD_WIN_NS = 16000;
  localparam int DT_UNIT_CYC = DT_UNIT_NS / 1000 * CLK_MHZ;
  localparam int BLANK0_CYC = BLANK0_NS / 1000 * CLK_MHZ;
  localparam int BLANK1_CYC = BLANK1_NS / 1000 * CLK_MHZ;
  localparam int FIX_CYC = FIX_NS / 1000 * CLK_MHZ;
  localparam logic [11:0] SD_WIN_CYC = 12'(SD_WIN_NS * CLK_MHZ / 1000);
  localparam logic [11:0] SD_HALF = 12'(SD_WIN_NS * CLK_MHZ / 2000);

  // --------------------------------------------------------------
  // Stall accumulator and sequencer
  // --------------------------------------------------------------
  localparam int ACC_W = 15;

  typedef enum logic [1:0] {
    GZSC_IDLE,
    GZSC_BLANK,
    GZSC_INTEG
  } gzsc_state_t;

endpackage

// *** gzsc_zeroing.sv ***
// Purpose: Return-home stepping, dwell timing and back-EMF stall decision
// Assumes: Serial framing is decoded elsewhere; sense_bit_i is an async comparator
// Notes: One gauge; config writes take effect at the next full step
//
// Behaviour
// - Delta-t is step code times 4.096 ms
// - Multiplier codes give factors 1, 2, 4
// - Blanking 512 us or 768 us
// - Dwell is delta-t times M plus blanking
// - Code zero: blanking plus 2.048 ms
// - Reset config gives 12.80 ms dwell
// - Blanking starts when a coil opens
// - Integrate undriven coil into 15-bit accumulator
// - Sign 0 continues, sign 1 stops
// - Integrator and accumulator restart each step
// - Accumulator sign appears on status bit fourteen
// - Preload is minus sixteen times value, minus one
// - Reset preload value is zero
// - Config word written at address 101
// - Full steps, one coil driven at a time

`timescale 1ns/1ns
`default_nettype none

// --------------------------------------------------------------
// Two-stage synchroniser for pins from outside the clock domain
// --------------------------------------------------------------
module gzsc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } gzsc_sync_regs_t;

  gzsc_sync_regs_t r_q;
  gzsc_sync_regs_t r_d;

  always_comb begin
    r_d = r_q;
    r_d.meta = async_i;
    // Only the second stage is read downstream
    r_d.stable = r_q.meta;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign sync_o = r_q.stable;

endmodule

// --------------------------------------------------------------
// Full-step dwell and blanking length from a configuration
// --------------------------------------------------------------
module gzsc_dwell #(
  parameter int unsigned DT_UNIT_CYCLES = gzsc_pkg::DT_UNIT_CYC,
  parameter int unsigned BLANK0_CYCLES = gzsc_pkg::BLANK0_CYC,
  parameter int unsigned BLANK1_CYCLES = gzsc_pkg::BLANK1_CYC,
  parameter int unsigned FIX_CYCLES = gzsc_pkg::FIX_CYC
) (
  input wire logic [1:0] mult_i,
  input wire logic blank_sel_i,
  input wire logic [3:0] delta_i,
  output logic [31:0] blank_o,
  output logic [31:0] dwell_o
);
  always_comb begin
    blank_o = blank_sel_i ? 32'(BLANK1_CYCLES) : 32'(BLANK0_CYCLES);
    if (delta_i == 4'h0) begin
      dwell_o = blank_o + 32'(FIX_CYCLES);
    end else begin
      // Code 3 on the multiplier gives 8, overflow is the host's risk
      dwell_o = ((32'(delta_i) * 32'(DT_UNIT_CYCLES)) << mult_i) + blank_o;
    end
  end

endmodule

module gzsc_zeroing #(
  parameter int unsigned DT_UNIT_CYCLES = gzsc_pkg::DT_UNIT_CYC,
  parameter int unsigned BLANK0_CYCLES = gzsc_pkg::BLANK0_CYC,
  parameter int unsigned BLANK1_CYCLES = gzsc_pkg::BLANK1_CYC,
  parameter int unsigned FIX_CYCLES = gzsc_pkg::FIX_CYC
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic cfg_wr_i,
  input wire logic [2:0] cfg_addr_i,
  input wire logic [gzsc_pkg::CFG_W-1:0] cfg_data_i,
  input wire logic home_start_i,
  input wire logic home_stop_i,
  input wire logic home_dir_i,
  input wire logic home_uncond_i,
  input wire logic status_sel_acc_i,
  input wire logic sense_bit_i,
  output logic coil_a_en_o,
  output logic coil_a_pol_o,
  output logic coil_b_en_o,
  output logic coil_b_pol_o,
  output logic home_active_o,
  output logic stall_seen_o,
  output logic step_done_o,
  output logic [gzsc_pkg::ACC_W-1:0] acc_result_o,
  output logic status_bit_fourteen_o
);
  import gzsc_pkg::*;

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mult;
    logic [5:0] preload_value;
    logic blank_sel;
    logic [3:0] delta;
    gzsc_state_t st;
    logic [31:0] timer;
    logic [31:0] dwell;
    logic [31:0] blank;
    logic [11:0] win;
    logic [11:0] ones;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] result;
    logic [1:0] phase;
    logic dir;
    logic uncond;
    logic active;
    logic stall;
    logic done;
    logic a_en;
    logic a_pol;
    logic b_en;
    logic b_pol;
    logic stat14;
  } gzsc_regs_t;

  gzsc_regs_t r_q;
  gzsc_regs_t r_d;
  logic [31:0] blank_c;
  logic [31:0] dwell_c;
  logic [1:0] next_phase;
  logic [ACC_W-1:0] acc_next;
  logic sense_sync_s;

  // --------------------------------------------------------------
  // Sense bit synchroniser
  // --------------------------------------------------------------
  gzsc_sync #(
    .WIDTH(1)
  ) sense_sync (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .async_i(sense_bit_i),
    .sync_o(sense_sync_s)
  );

  // --------------------------------------------------------------
  // Step timing from the live configuration
  // --------------------------------------------------------------
  gzsc_dwell #(
    .DT_UNIT_CYCLES(DT_UNIT_CYCLES),
    .BLANK0_CYCLES(BLANK0_CYCLES),
    .BLANK1_CYCLES(BLANK1_CYCLES),
    .FIX_CYCLES(FIX_CYCLES)
  ) step_timing (
    .mult_i(r_q.mult),
    .blank_sel_i(r_q.blank_sel),
    .delta_i(r_q.delta),
    .blank_o(blank_c),
    .dwell_o(dwell_c)
  );

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.stat14 = status_sel_acc_i ? r_q.result[ACC_W-1] : 1'b0;
    next_phase = r_q.dir ? r_q.phase - 2'h1 : r_q.phase + 2'h1;
    acc_next = r_q.acc;

    if (cfg_wr_i && cfg_addr_i == ZSC_ADDR) begin
      // Stored now, sampled only at a step boundary
      r_d.mult = cfg_data_i[MULT_LSB+:2];
      r_d.preload_value = cfg_data_i[PRE_LSB+:6];
      r_d.blank_sel = cfg_data_i[BLANK_BIT];
      r_d.delta = cfg_data_i[DELTA_LSB+:4];
    end

    case (r_q.st)
      GZSC_IDLE: begin
        r_d.active = 1'b0;
        r_d.a_en = 1'b0;
        r_d.b_en = 1'b0;
        if (home_start_i) begin
          r_d.active = 1'b1;
          r_d.stall = 1'b0;
          r_d.dir = home_dir_i;
          r_d.uncond = home_uncond_i;
          r_d.st = GZSC_BLANK;
          r_d.timer = 32'h0;
          r_d.dwell = dwell_c;
          r_d.blank = blank_c;
          r_d.acc = ~{5'h00, r_q.preload_value, 4'h0};
          // First step drives coil A positive, B open
          r_d.phase = 2'h0;
          r_d.a_en = 1'b1;
          r_d.b_en = 1'b0;
          r_d.a_pol = 1'b1;
          r_d.b_pol = 1'b1;
          r_d.win = 12'h0;
          r_d.ones = 12'h0;
        end
      end
      GZSC_BLANK, GZSC_INTEG: begin
        r_d.timer = r_q.timer + 32'h1;
        if (r_q.st == GZSC_BLANK && r_q.timer == r_q.blank - 32'h1) begin
          r_d.st = GZSC_INTEG;
        end
        if (r_q.st == GZSC_INTEG) begin
          // Bitstream decimation, one accumulator count per window
          if (r_q.win == SD_WIN_CYC - 12'h1) begin
            acc_next = (r_q.ones + 12'(sense_sync_s) >= SD_HALF) ? r_q.acc + 15'h0001 : r_q.acc - 15'h0001;
            r_d.acc = acc_next;
            r_d.win = 12'h0;
            r_d.ones = 12'h0;
          end else begin
            r_d.win = r_q.win + 12'h1;
            r_d.ones = r_q.ones + 12'(sense_sync_s);
          end
        end
        if (r_q.timer == r_q.dwell - 32'h1) begin
          r_d.result = acc_next;
          r_d.done = 1'b1;
          if (acc_next[ACC_W-1] && !r_q.uncond) begin
            r_d.st = GZSC_IDLE;
            r_d.stall = 1'b1;
            r_d.active = 1'b0;
            r_d.a_en = 1'b0;
            r_d.b_en = 1'b0;
          end else begin
            r_d.st = GZSC_BLANK;
            r_d.phase = next_phase;
            r_d.timer = 32'h0;
            r_d.dwell = dwell_c;
            r_d.blank = blank_c;
            r_d.acc = ~{5'h00, r_q.preload_value, 4'h0};
            r_d.win = 12'h0;
            r_d.ones = 12'h0;
          end
        end
        if (r_d.active) begin
          // One coil driven, the other left open for sensing
          r_d.a_en = ~r_d.phase[0];
          r_d.b_en = r_d.phase[0];
          r_d.a_pol = ~r_d.phase[1];
          r_d.b_pol = ~r_d.phase[1];
        end
        if (home_stop_i) begin
          r_d.st = GZSC_IDLE;
          r_d.active = 1'b0;
          r_d.a_en = 1'b0;
          r_d.b_en = 1'b0;
        end
      end
      default: begin
        r_d.st = GZSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      r_q <= '0;
      r_q.st <= GZSC_IDLE;
      r_q.mult <= MULT_RST;
      r_q.blank_sel <= BLANK_RST;
      r_q.delta <= DELTA_RST;
      r_q.preload_value <= PRE_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign coil_a_en_o = r_q.a_en;
  assign coil_a_pol_o = r_q.a_pol;
  assign coil_b_en_o = r_q.b_en;
  assign coil_b_pol_o = r_q.b_pol;
  assign home_active_o = r_q.active;
  assign stall_seen_o = r_q.stall;
  assign step_done_o = r_q.done;
  assign acc_result_o = r_q.result;
  assign status_bit_fourteen_o = r_q.stat14;

endmodule

`default_nettype wire

// *** gzsc_zeroing_sva.sv ***
// Purpose: Port checks of gzsc_zeroing
// Assumes: Unconditional mode held during a run
// Notes: Bound below
`timescale 1ns/1ns
`default_nettype none
module gzsc_zeroing_chk (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic home_start_i,
  input wire logic home_uncond_i,
  input wire logic status_sel_acc_i,
  input wire logic coil_a_en_o,
  input wire logic coil_b_en_o,
  input wire logic home_active_o,
  input wire logic stall_seen_o,
  input wire logic step_done_o,
  input wire logic [gzsc_pkg::ACC_W-1:0] acc_result_o,
  input wire logic status_bit_fourteen_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_one_coil: assert property (!(coil_a_en_o && coil_b_en_o)) else $error("two coils");
  a_idle_coils_off: assert property (!home_active_o |-> !coil_a_en_o && !coil_b_en_o) else $error("coil idle");
  a_start_drive: assert property (home_start_i && !home_active_o |=> home_active_o && coil_a_en_o) else $error("start");
  a_sign_stops: assert property (step_done_o && acc_result_o[14] && !home_uncond_i |-> ##[0:1] (!home_active_o && stall_seen_o)) else $error("no stop");
  a_sign_goes: assert property (step_done_o && !acc_result_o[14] |-> home_active_o) else $error("stopped");
  a_acc_at_end: assert property ($changed(acc_result_o) |-> step_done_o) else $error("acc moved");
  a_status_sign: assert property (status_sel_acc_i && acc_result_o[14] |=> status_bit_fourteen_o) else $error("status_bit_fourteen");
  a_status_off: assert property (!status_sel_acc_i |=> !status_bit_fourteen_o) else $error("status_bit_fourteen off");
  cover property (step_done_o && !acc_result_o[14]);
  cover property ($rose(stall_seen_o));
  cover property (status_bit_fourteen_o);
endmodule
bind gzsc_zeroing gzsc_zeroing_chk chk (.clock_i(clock_i), .reset_i(reset_i), .home_start_i(home_start_i),
  .home_uncond_i(home_uncond_i), .status_sel_acc_i(status_sel_acc_i), .coil_a_en_o(coil_a_en_o),
  .coil_b_en_o(coil_b_en_o), .home_active_o(home_active_o), .stall_seen_o(stall_seen_o),
  .step_done_o(step_done_o), .acc_result_o(acc_result_o), .status_bit_fourteen_o(status_bit_fourteen_o));
`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench of gzsc_zeroing
// Assumes: Shortened timing parameters
// Notes: Motor model feeds the sense bit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import gzsc_pkg::*;
  localparam int DT = 100, B0 = 8, B1 = 12, FX = 20;
  logic clock_i = 0, reset_i = 1, cfg_wr_i = 0, home_start_i = 0, home_stop_i = 0, home_dir_i = 0;
  logic home_uncond_i = 1, status_sel_acc_i = 0, sense_bit_i, moving = 0, ca, cb, act, stall, done;
  logic st14, exp14 = 0;
  logic [2:0] cfg_addr_i = 0;
  logic [CFG_W-1:0] cfg_data_i = 0;
  logic [ACC_W-1:0] acc;
  int n_errors = 0, compares = 0, cyc = 0, seed = 82210, tick = 0, gap = 0;
  always #2 clock_i = ~clock_i;
  gzsc_zeroing #(.DT_UNIT_CYCLES(DT), .BLANK0_CYCLES(B0), .BLANK1_CYCLES(B1), .FIX_CYCLES(FX)) dut (
    .clock_i(clock_i), .reset_i(reset_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_data_i(cfg_data_i),
    .home_start_i(home_start_i), .home_stop_i(home_stop_i), .home_dir_i(home_dir_i),
    .home_uncond_i(home_uncond_i), .status_sel_acc_i(status_sel_acc_i), .sense_bit_i(sense_bit_i),
    .coil_a_en_o(ca), .coil_a_pol_o(), .coil_b_en_o(cb), .coil_b_pol_o(), .home_active_o(act),
    .stall_seen_o(stall), .step_done_o(done), .acc_result_o(acc), .status_bit_fourteen_o(st14));
  gzsc_motor_model motor (.clock_i(clock_i), .coil_a_en_i(ca), .coil_b_en_i(cb), .moving_i(moving),
    .sense_bit_o(sense_bit_i));
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 32'h7fffffff;
  endfunction
  function automatic int dwell(logic [CFG_W-1:0] c);
    int b;
    b = c[BLANK_BIT] ? B1 : B0;
    return c[3:0] == 0 ? b + FX : ((DT * c[3:0]) << c[12:11]) + b;
  endfunction
  function automatic logic [ACC_W-1:0] acc_exp(logic [CFG_W-1:0] c, logic mv);
    int w;
    w = (dwell(c) - (c[BLANK_BIT] ? B1 : B0)) / 4000;
    return ACC_W'(-16 * int'(c[10:5]) - 1 + (mv ? w : -w));
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (e !== g) begin
      n_errors++;
      $display("mismatch %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [CFG_W-1:0] d);
    @(posedge clock_i);
    cfg_wr_i <= 1;
    cfg_addr_i <= a;
    cfg_data_i <= d;
    @(posedge clock_i);
    cfg_wr_i <= 0;
  endtask
  task automatic wait_done(output int c);
    c = 0;
    do begin
      @(negedge clock_i);
      c++;
    end while (done !== 1 && c < 30000);
    if (c >= 30000) n_errors++;
    @(posedge clock_i);
  endtask
  // Outputs are read mid-cycle; gap is the edge count between step pulses
  always @(negedge clock_i) begin
    chk("status14", exp14, st14);
    exp14 <= status_sel_acc_i && acc[ACC_W-1];
    if (done === 1'b1) begin
      gap <= tick;
      tick <= 1;
    end else begin
      tick <= tick + 1;
    end
  end
  task automatic go(logic u);
    home_uncond_i <= u;
    home_dir_i <= 1'(rnd());
    home_start_i <= 1;
    @(posedge clock_i);
    home_start_i <= 0;
  endtask
  // Second step keeps a, the write made within it shows from the third
  task automatic run(logic [CFG_W-1:0] a, logic [CFG_W-1:0] b, bit w);
    int n;
    if (w) wr(3'h5, a);
    wr(3'h5 ^ 3'(1 + rnd() % 7), b);
    moving <= 1'(rnd());
    go(1);
    wait_done(n);
    wr(3'h5, b);
    wait_done(n);
    chk("dwell", dwell(a), gap);
    chk("acc", acc_exp(a, moving), acc);
    wait_done(n);
    chk("dwell", dwell(b), gap);
    chk("acc", acc_exp(b, moving), acc);
    home_stop_i <= 1;
    @(posedge clock_i);
    home_stop_i <= 0;
  endtask
  function automatic logic [CFG_W-1:0] rcfg();
    return {2'(rnd() % 3), 6'(rnd()), 1'(rnd()), 4'(rnd())};
  endfunction
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    status_sel_acc_i <= 1'(rnd());
    cyc++;
    if (cyc == 100000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    int n;
    repeat (4) @(posedge clock_i);
    reset_i <= 0;
    run(13'h0003, {2'h2, 6'h3f, 1'b1, 4'hf}, 0);
    moving <= 0;
    wr(3'h5, 13'h0000);
    go(0);
    wait_done(n);
    repeat (2) @(posedge clock_i);
    chk("active", 0, act);
    chk("stall", 1, stall);
    run({2'h1, 6'h01, 1'b0, 4'h0}, {2'h2, 6'h00, 1'b0, 4'ha}, 1);
    repeat (5) run(rcfg(), rcfg(), 1);
    complete_run();
  end
endmodule
`default_nettype wire
